/* File: pkg/sssc_regs.vh */
// register map, field positions, reset values and protocol constants of the spi slave port
`ifndef SSSC_REGS_VH
`define SSSC_REGS_VH

// apb byte addresses
`define SSSC_STATUS_ADDR 16'h2708
`define SSSC_CTRL_ADDR 16'h270c
`define SSSC_CMD_ADDR 16'h2710
`define SSSC_PINMAP_ADDR 16'h2714

// control register fields
`define SSSC_CTRL_EN_BIT 4
`define SSSC_CTRL_SAFE_BIT 3
`define SSSC_CTRL_EN_RST 1'b1
`define SSSC_CTRL_SAFE_RST 1'b0
`define SSSC_PINMAP_RST 4'h0

// status register fields
`define SSSC_ST_RDY_ERR 7
`define SSSC_ST_RD_PAR 6
`define SSSC_ST_WR_PAR 5
`define SSSC_ST_CNT_HI 4
`define SSSC_ST_CNT_LO 2
`define SSSC_ST_FLASH 1
`define SSSC_ST_FLASH_RDY 0
`define SSSC_STATUS_RST 8'h00
`define SSSC_SHORT_CNT 3'h7

// transaction framing
`define SSSC_HDR_BYTES 3'h3
`define SSSC_CMD_RD_BIT 7
`define SSSC_SAFE_BASE 16'h0400
`define SSSC_SAFE_SIZE 17'h00010

`endif

/* File: design/sssc_pin_sync.v */
// two-stage synchronisers and edge detection for the spi slave pins and the test pin
`default_nettype none

module sssc_pin_sync (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // raw pins
   input wire sclk_pin,
   input wire cs_n_pin,
   input wire mosi_pin,
   input wire test_pin,
   // synchronised levels and edges
   output wire sclk_rise,
   output wire sclk_fall,
   output wire cs_n_sync,
   output wire cs_n_rise,
   output wire mosi_sync,
   output wire test_sync
);

   reg [3:0] meta_reg;
   reg [3:0] sync_reg;
   reg sclk_old_reg;
   reg cs_n_old_reg;

   // first stage is read only by the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 4'h2;
         sync_reg <= 4'h2;
         sclk_old_reg <= 1'b0;
         cs_n_old_reg <= 1'b1;
      end else begin
         meta_reg <= {test_pin, mosi_pin, cs_n_pin, sclk_pin};
         sync_reg <= meta_reg;
         sclk_old_reg <= sync_reg[0];
         cs_n_old_reg <= sync_reg[1];
      end
   end

   assign sclk_rise = sync_reg[0] & ~sclk_old_reg;
   assign sclk_fall = ~sync_reg[0] & sclk_old_reg;
   assign cs_n_sync = sync_reg[1];
   assign cs_n_rise = sync_reg[1] & ~cs_n_old_reg;
   assign mosi_sync = sync_reg[2];
   assign test_sync = sync_reg[3];

endmodule

`default_nettype wire

/* File: design/sssc_top.v */
// spi slave port control: pin enable, write guard, command capture and transfer status
//
// Added by the designer: the APB interface to the registers.
`include "sssc_regs.vh"
`default_nettype none

// How it works
// - enable bit routes the spi port to four shared pins when their map bits are zero
// - guard bit limits master writes to the command byte and a 16-byte ram window
// - read-only 8-bit status register is refreshed at the end of each transaction
// - status bit 7 flags a read or write the port could not perform, not ready
// - status bit 6 is parity of bytes fetched for the master, the byte prefetched after the last one included
// - status bit 5 is parity of all bytes the master sent, command and address included
// - status bits 4..2 hold low three bits of the data byte count
// - transactions of one to three bytes report 111 in the count field
// - status bit 1 shows flash programming mode and reads zero while test pin is low
// - status bit 0 shows flash ready for another write while in flash mode
// - master sends an 8-bit command byte, captured into a firmware-readable register
module sssc_top (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // spi pins, reaching the shared segment io pins
   input wire sclk_pin,
   input wire cs_n_pin,
   input wire mosi_pin,
   output reg miso_out,
   output reg miso_oe,
   output reg shared_segment_io_pin_spi_sel,
   // test pin and flash controller
   input wire test_pin,
   input wire flash_mode,
   input wire flash_ready,
   // on-chip memory port
   input wire mem_ready,
   input wire [7:0] mem_rdata,
   output reg [15:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg mem_we,
   output reg mem_re
);

   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_CMD = 4'h2;
   localparam [3:0] ST_ADDR = 4'h4;
   localparam [3:0] ST_DATA = 4'h8;

   wire sclk_rise;
   wire sclk_fall;
   wire cs_n_sync;
   wire cs_n_rise;
   wire mosi_sync;
   wire test_sync;

   sssc_pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .sclk_pin(sclk_pin),
      .cs_n_pin(cs_n_pin),
      .mosi_pin(mosi_pin),
      .test_pin(test_pin),
      .sclk_rise(sclk_rise),
      .sclk_fall(sclk_fall),
      .cs_n_sync(cs_n_sync),
      .cs_n_rise(cs_n_rise),
      .mosi_sync(mosi_sync),
      .test_sync(test_sync)
   );

   // software registers
   reg en_reg;
   reg safe_reg;
   reg [3:0] pinmap_reg;
   reg [7:0] status_reg;
   reg [7:0] cmd_reg;

   // transaction state
   reg [3:0] state_reg;
   reg [2:0] bit_reg;
   reg [7:0] rx_reg;
   reg [6:0] tx_reg;
   reg addr_byte_reg;
   reg rd_cmd_reg;
   reg [2:0] total_reg;
   reg [2:0] data_cnt_reg;
   reg wr_par_reg;
   reg rd_par_reg;
   reg rdy_err_reg;
   reg load_tx_reg;

   // port is live only with the enable set and all four pin map bits cleared
   wire port_on = en_reg & (pinmap_reg == 4'h0);
   wire selected = port_on & ~cs_n_sync;
   wire byte_done = selected & sclk_rise & (bit_reg == 3'h7);
   wire [7:0] rx_byte = {rx_reg[6:0], mosi_sync};

   // window test used by the write path guard
   function in_window;
      input [15:0] a;
      reg [16:0] d;
      begin
         d = {1'b0, a} - {1'b0, `SSSC_SAFE_BASE};
         in_window = (a >= `SSSC_SAFE_BASE) && (d < `SSSC_SAFE_SIZE);
      end
   endfunction

   function xor8;
      input [7:0] b;
      begin
         xor8 = ^b;
      end
   endfunction

   wire wr_allowed = ~safe_reg | in_window(mem_addr);

   // apb decode happens in the setup cycle so the access phase answers from flops
   wire apb_setup = psel & ~penable;
   wire apb_write = psel & penable & pready & pwrite;
   wire hit_status = (paddr == `SSSC_STATUS_ADDR);
   wire hit_ctrl = (paddr == `SSSC_CTRL_ADDR);
   wire hit_cmd = (paddr == `SSSC_CMD_ADDR);
   wire hit_pinmap = (paddr == `SSSC_PINMAP_ADDR);
   wire hit_any = hit_status | hit_ctrl | hit_cmd | hit_pinmap;

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit_status) begin
         rd_mux = {24'h00_0000, status_reg};
      end else if (hit_ctrl) begin
         rd_mux[`SSSC_CTRL_EN_BIT] = en_reg;
         rd_mux[`SSSC_CTRL_SAFE_BIT] = safe_reg;
      end else if (hit_cmd) begin
         rd_mux = {24'h00_0000, cmd_reg};
      end else if (hit_pinmap) begin
         rd_mux = {28'h000_0000, pinmap_reg};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~hit_any;
         if (apb_setup && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // writable control; status and command are read only, writes to them are dropped
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= `SSSC_CTRL_EN_RST;
         safe_reg <= `SSSC_CTRL_SAFE_RST;
         pinmap_reg <= `SSSC_PINMAP_RST;
      end else if (apb_write) begin
         if (hit_ctrl) begin
            en_reg <= pwdata[`SSSC_CTRL_EN_BIT];
            safe_reg <= pwdata[`SSSC_CTRL_SAFE_BIT];
         end
         if (hit_pinmap) begin
            pinmap_reg <= pwdata[3:0];
         end
      end
   end

   // pin routing and miso drive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_segment_io_pin_spi_sel <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         shared_segment_io_pin_spi_sel <= port_on;
         miso_oe <= selected;
      end
   end

   // byte framing: command, two address bytes, then data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         bit_reg <= 3'h0;
         rx_reg <= 8'h00;
         addr_byte_reg <= 1'b0;
         rd_cmd_reg <= 1'b0;
         cmd_reg <= 8'h00;
         total_reg <= 3'h0;
         data_cnt_reg <= 3'h0;
         wr_par_reg <= 1'b0;
      end else if (!selected) begin
         state_reg <= ST_IDLE;
         bit_reg <= 3'h0;
      end else begin
         if (sclk_rise) begin
            rx_reg <= rx_byte;
            bit_reg <= bit_reg + 3'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               // a fresh frame clears the per-transaction tallies
               state_reg <= ST_CMD;
               bit_reg <= 3'h0;
               addr_byte_reg <= 1'b0;
               total_reg <= 3'h0;
               data_cnt_reg <= 3'h0;
               wr_par_reg <= 1'b0;
            end
            ST_CMD: begin
               if (byte_done) begin
                  cmd_reg <= rx_byte;
                  rd_cmd_reg <= rx_byte[`SSSC_CMD_RD_BIT];
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (byte_done) begin
                  addr_byte_reg <= 1'b1;
                  if (addr_byte_reg) begin
                     state_reg <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (byte_done) begin
                  data_cnt_reg <= data_cnt_reg + 3'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         if (byte_done) begin
            wr_par_reg <= wr_par_reg ^ xor8(rx_byte);
            if (total_reg != 3'h4) begin
               total_reg <= total_reg + 3'h1;
            end
         end
      end
   end

   // memory side: address load, guarded writes, reads ahead of each outgoing byte
   wire addr_done = byte_done & (state_reg == ST_ADDR) & addr_byte_reg;
   wire data_done = byte_done & (state_reg == ST_DATA);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         rdy_err_reg <= 1'b0;
         load_tx_reg <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         // fetched data stands the cycle after the strobe, so the load trails mem_re
         load_tx_reg <= mem_re;
         if (selected && state_reg == ST_IDLE) begin
            rdy_err_reg <= 1'b0;
         end
         if (byte_done && state_reg == ST_ADDR) begin
            if (addr_byte_reg) begin
               mem_addr[7:0] <= rx_byte;
            end else begin
               mem_addr[15:8] <= rx_byte;
            end
         end
         if (addr_done && rd_cmd_reg) begin
            // first read byte is fetched as soon as the address is known
            mem_re <= mem_ready;
            rdy_err_reg <= rdy_err_reg | ~mem_ready;
         end
         if (data_done && !rd_cmd_reg) begin
            mem_wdata <= rx_byte;
            // blocked writes are discarded without an error flag
            mem_we <= mem_ready & wr_allowed;
            rdy_err_reg <= rdy_err_reg | ~mem_ready;
         end
         if (data_done && rd_cmd_reg) begin
            mem_addr <= mem_addr + 16'h0001;
            mem_re <= mem_ready;
            rdy_err_reg <= rdy_err_reg | ~mem_ready;
         end
         // write address advances once the strobe has been seen, or at the data byte when no strobe is issued
         if (mem_we) begin
            mem_addr <= mem_addr + 16'h0001;
         end else if (data_done && !rd_cmd_reg && !(mem_ready & wr_allowed)) begin
            mem_addr <= mem_addr + 16'h0001;
         end
      end
   end

   // miso shifts on falling sclk; a freshly loaded byte must not be shifted before use
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_out <= 1'b0;
         tx_reg <= 7'h00;
         rd_par_reg <= 1'b0;
      end else if (!selected) begin
         miso_out <= 1'b0;
         tx_reg <= 7'h00;
      end else begin
         if (state_reg == ST_IDLE) begin
            rd_par_reg <= 1'b0;
         end
         if (load_tx_reg) begin
            miso_out <= mem_rdata[7];
            tx_reg <= mem_rdata[6:0];
            rd_par_reg <= rd_par_reg ^ xor8(mem_rdata);
         end else if (sclk_fall && bit_reg != 3'h0) begin
            miso_out <= tx_reg[6];
            tx_reg <= {tx_reg[5:0], 1'b0};
         end
      end
   end

   // status: transfer flags latch at frame end, flash flags follow their sources
   wire flash_on = flash_mode & test_sync;
   wire [2:0] cnt_field = (total_reg <= `SSSC_HDR_BYTES) ? `SSSC_SHORT_CNT : data_cnt_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= `SSSC_STATUS_RST;
      end else begin
         if (cs_n_rise && port_on) begin
            status_reg[`SSSC_ST_RDY_ERR] <= rdy_err_reg;
            status_reg[`SSSC_ST_RD_PAR] <= rd_par_reg;
            status_reg[`SSSC_ST_WR_PAR] <= wr_par_reg;
            status_reg[`SSSC_ST_CNT_HI:`SSSC_ST_CNT_LO] <= cnt_field;
         end
         status_reg[`SSSC_ST_FLASH] <= flash_on;
         status_reg[`SSSC_ST_FLASH_RDY] <= flash_on & flash_ready;
      end
   end

endmodule

`default_nettype wire

/* File: bench/sssc_assertions.sv */
// concurrent checks on the ports of the spi slave port block
`include "sssc_regs.vh"
`default_nettype none
module sssc_assertions (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // spi and pins
   input wire cs_n_pin,
   input wire miso_oe,
   input wire shared_segment_io_pin_spi_sel,
   input wire test_pin,
   input wire flash_ready,
   // memory
   input wire mem_we,
   input wire mem_re
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd_st = pready && !pwrite && paddr == `SSSC_STATUS_ADDR;
   AST_ANSWER: assert property (psel && !penable |=> pready) else $error("no access answer");
   AST_ONE: assert property (pready |=> !pready) else $error("ready held too long");
   AST_UNMAP: assert property (pready |-> pslverr == !(paddr inside {`SSSC_STATUS_ADDR,
      `SSSC_CTRL_ADDR, `SSSC_CMD_ADDR, `SSSC_PINMAP_ADDR})) else $error("bad error flag");
   AST_ERRDATA: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("data on error");
   AST_OFF: assert property (!shared_segment_io_pin_spi_sel [*2] |-> !miso_oe)
      else $error("drives while off");
   AST_IDLE: assert property (cs_n_pin [*6] |-> !miso_oe) else $error("drives unselected");
   AST_TEST: assert property (!test_pin [*6] ##0 rd_st |-> !prdata[1])
      else $error("flash mode with test low");
   AST_FRDY: assert property (!flash_ready [*3] ##0 rd_st |-> !prdata[0])
      else $error("flash ready while busy");
   AST_WE: assert property (mem_we |=> !mem_we) else $error("write pulse too long");
   AST_RE: assert property (mem_re |=> !mem_re ##1 !mem_re) else $error("fetch too close");
endmodule
bind sssc_top sssc_assertions sssc_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .cs_n_pin, .miso_oe, .shared_segment_io_pin_spi_sel,
   .test_pin, .flash_ready, .mem_we, .mem_re);
`default_nettype wire

/* File: bench/sssc_spi_master.sv */
// behavioural spi bus master: mode 0, msb first, clock still between frames
`default_nettype none
module sssc_spi_master (
   // serial pins
   output logic sclk_pin,
   output logic cs_n_pin,
   output logic mosi_pin,
   input wire miso
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx [0:15];
   logic [7:0] rx [0:15];
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      mosi_pin = 1'b0;
   end
   // byte 0 is always the command byte
   task automatic xfer(input int n);
      // an offset keeps every pin edge off the pclk sampling edges
      #0.3;
      cs_n_pin = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            mosi_pin = tx[i][b];
            #62.5;
            sclk_pin = 1'b1;
            rx[i][b] = miso;
            #62.5;
            sclk_pin = 1'b0;
         end
      end
      #100;
      // released data line must not keep the last bit
      mosi_pin = ~mosi_pin;
      cs_n_pin = 1'b1;
      #200;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench of the spi slave port block
`include "sssc_regs.vh"
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic test_pin = 1'b0, flash_mode = 1'b0, flash_ready = 1'b0, mem_ready = 1'b1;
   logic [7:0] mem_rdata = 8'h0;
   wire [31:0] prdata;
   wire pready, pslverr, miso_out, miso_oe, shared_segment_io_pin_spi_sel, mem_we, mem_re;
   wire [15:0] mem_addr;
   wire [7:0] mem_wdata;
   wire sclk_pin, cs_n_pin, mosi_pin;
   wire miso = miso_oe ? miso_out : 1'bz;
   logic [32:0] rq[$], ex;
   logic [23:0] wq[$], ew;
   logic [7:0] last = 8'h0, lcmd = 8'h0;
   logic guard = 1'b0;
   int checks = 0, miscompares = 0, seed = 73;
   sssc_top sssc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sclk_pin, .cs_n_pin, .mosi_pin, .miso_out, .miso_oe,
      .shared_segment_io_pin_spi_sel, .test_pin, .flash_mode, .flash_ready, .mem_ready,
      .mem_rdata, .mem_addr, .mem_wdata, .mem_we, .mem_re);
   sssc_spi_master sssc_spi_master_inst (.sclk_pin, .cs_n_pin, .mosi_pin, .miso);
   initial begin
      forever #4 pclk = ~pclk;
   end
   // memory stub: data is a fixed function of the address
   always @(posedge pclk) begin
      mem_rdata <= mem_addr[7:0] ^ 8'ha5;
      if (psel && penable && pready && !pwrite) begin
         ex = rq.pop_front();
         `CHK({pslverr, prdata}, ex)
      end
      if (mem_we) begin
         ew = wq.pop_front();
         `CHK({mem_addr, mem_wdata}, ew)
      end
   end
   task automatic end_of_test;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
         input logic [32:0] e);
      int n;
      n = 0;
      if (!w) rq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ready is sampled at each rising edge; the request stands until it is seen high
      @(posedge pclk);
      while (!pready && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n == 50) miscompares++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one frame of n bytes; on=0 means the port is expected to ignore it
   task automatic xf(input logic [7:0] cmd, input logic [15:0] a, input int n, input logic on);
      logic wp, rp;
      logic [15:0] x;
      wp = 1'b0;
      rp = 1'b0;
      sssc_spi_master_inst.tx[0] = cmd;
      sssc_spi_master_inst.tx[1] = a[15:8];
      sssc_spi_master_inst.tx[2] = a[7:0];
      for (int i = 0; i < n; i++) begin
         x = a + 16'(i - 3);
         if (i > 2) sssc_spi_master_inst.tx[i] = cmd[7] ? 8'h0 : 8'($random(seed));
         wp ^= ^sssc_spi_master_inst.tx[i];
         if (on && i > 2 && !cmd[7] && mem_ready && (!guard || x[15:4] == 12'h040))
            wq.push_back({x, sssc_spi_master_inst.tx[i]});
         if (i > 1 && cmd[7]) rp ^= ^((x[7:0] + 8'h1) ^ 8'ha5);
      end
      sssc_spi_master_inst.xfer(n);
      for (int i = 3; i < n; i++)
         if (cmd[7]) `CHK(sssc_spi_master_inst.rx[i], 8'(a + 16'(i - 3)) ^ 8'ha5)
      if (on) begin
         last = {n > 3 && !mem_ready, rp, wp, n <= 3 ? 3'h7 : 3'(n - 3), 2'b00};
         lcmd = cmd;
      end
      apb(0, `SSSC_STATUS_ADDR, 32'h0, {25'h0, last});
      apb(0, `SSSC_CMD_ADDR, 32'h0, {25'h0, lcmd});
   endtask
   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      `CHK(shared_segment_io_pin_spi_sel, 1'b1)
      apb(0, `SSSC_STATUS_ADDR, 32'h0, 33'h0);
      apb(0, `SSSC_CTRL_ADDR, 32'h0, 33'h10);
      apb(0, `SSSC_CMD_ADDR, 32'h0, 33'h0);
      apb(0, 16'h2700, 32'h0, {1'b1, 32'h0});
      apb(1, `SSSC_STATUS_ADDR, 32'hff, 33'h0);
      apb(1, `SSSC_PINMAP_ADDR, 32'hffff_ffff, 33'h0);
      apb(0, `SSSC_PINMAP_ADDR, 32'h0, 33'hf);
      $display("test registers done");
      `CHK(shared_segment_io_pin_spi_sel, 1'b0)
      xf(8'h01, 16'h0400, 6, 1'b0);
      apb(1, `SSSC_PINMAP_ADDR, 32'h0, 33'h0);
      repeat (4) @(posedge pclk);
      $display("test port off done");
      xf(8'h12, 16'h0400, 12, 1'b1);
      apb(1, `SSSC_CTRL_ADDR, 32'h18, 33'h0);
      apb(0, `SSSC_CTRL_ADDR, 32'h0, 33'h18);
      guard = 1'b1;
      xf(8'h13, 16'h040e, 6, 1'b1);
      xf(8'h14, 16'h0100, 4, 1'b1);
      apb(1, `SSSC_CTRL_ADDR, 32'h10, 33'h0);
      guard = 1'b0;
      $display("test writes and guard done");
      for (int n = 1; n <= 3; n++) xf(8'h20 + 8'(n), 16'h0, n, 1'b1);
      xf(8'h80, 16'h00fe, 7, 1'b1);
      mem_ready <= 1'b0;
      // let the new level settle before the frame's expectations are noted
      @(posedge pclk);
      xf(8'h15, 16'h0400, 5, 1'b1);
      mem_ready <= 1'b1;
      $display("test short, read and not ready done");
      test_pin <= 1'b1;
      flash_mode <= 1'b1;
      flash_ready <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(0, `SSSC_STATUS_ADDR, 32'h0, {25'h0, last | 8'h3});
      flash_ready <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(0, `SSSC_STATUS_ADDR, 32'h0, {25'h0, last | 8'h2});
      test_pin <= 1'b0;
      flash_ready <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(0, `SSSC_STATUS_ADDR, 32'h0, {25'h0, last});
      $display("test flash bits done");
      repeat (4) @(posedge pclk);
      `CHK(wq.size(), 0)
      end_of_test();
   end
endmodule
`default_nettype wire
